/* File: src/ris_top.sv */
`timescale 1ns/1ns
`default_nettype none
module ris_top
  import ris_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference status and pin
  input wire logic [1:0] reference_choice_pin,
  input wire logic primary_valid,
  input wire logic secondary_valid,
  // buffer and mux controls
  output logic [1:0] secondary_buffer_mode,
  output logic [1:0] primary_buffer_mode,
  output logic primary_enable,
  output logic secondary_enable,
  output logic secondary_buffer_gain,
  output logic primary_buffer_gain,
  output logic glitchfree_mux_skip,
  output logic first_loop_use_secondary,
  output logic second_loop_use_secondary
);

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] ctl;
    logic aw_got;
    logic [9:0] aw;
    logic w_got;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic xtal_off;
    logic [1:0] loop_sec;
    logic [1:0] auto_seen;
    logic [1:0] sec_mode;
    logic [1:0] pri_mode;
    logic pri_en;
    logic sec_en;
    logic sec_gain;
    logic pri_gain;
    logic skip;
  } ris_state_type;

  ris_state_type st_r, st_nxt;
  ris_pin_type pin_lvl;
  ris_loop_type pick1, pick2;

  // ----------------------------------------
  // reference selection
  // ----------------------------------------
  // pin codes 0 low, 1 mid, 2 or 3 high
  always_comb begin
    if (reference_choice_pin == 2'h0) begin
      pin_lvl = RIS_PIN_LOW;
    end else if (reference_choice_pin == 2'h1) begin
      pin_lvl = RIS_PIN_MID;
    end else begin
      pin_lvl = RIS_PIN_HIGH;
    end
  end

  ris_ref_pick #(
    .PIN_LOW_SEC(1'b0),
    .PIN_MID_SEC(1'b0)
  ) u_first (
    .choice(st_r.sel[RIS_LOOP1_LSB +: 2]),
    .pin(pin_lvl),
    .primary_valid(primary_valid),
    .pick(pick1)
  );

  ris_ref_pick #(
    .PIN_LOW_SEC(1'b1),
    .PIN_MID_SEC(1'b1)
  ) u_second (
    .choice(st_r.sel[RIS_LOOP2_LSB +: 2]),
    .pin(pin_lvl),
    .primary_valid(primary_valid),
    .pick(pick2)
  );

  function automatic logic [31:0] ris_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] mw;
    logic sw;
    mw = 32'h0;
    sw = 1'b0;
    st_nxt = st_r;
    // write channel
    if (s_axi_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wd = s_axi_wdata;
      st_nxt.ws = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RIS_RESP_OKAY;
      if (st_r.aw[9:2] == RIS_SELECT_IDX) begin
        mw = ris_merge({24'h0, st_r.sel}, st_r.wd, st_r.ws);
        st_nxt.sel = mw[7:0];
      end else if (st_r.aw[9:2] == RIS_CONTROL_IDX) begin
        mw = ris_merge({24'h0, st_r.ctl}, st_r.wd, st_r.ws);
        st_nxt.ctl = mw[7:0];
      end else if (st_r.aw[9:2] != RIS_STATUS_ADDR[9:2]) begin
        st_nxt.bresp = RIS_RESP_SLVERR;
      end
    end
    // address and data stay held until the response is taken
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
    end
    // read channel
    st_nxt.arready = 1'b0;
    if (s_axi_arvalid && !st_r.arready && !st_r.rvalid) begin
      st_nxt.arready = 1'b1;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RIS_RESP_OKAY;
      st_nxt.rdata = 32'h0;
      if (s_axi_araddr[9:2] == RIS_SELECT_IDX) begin
        st_nxt.rdata = {24'h0, st_r.sel};
      end else if (s_axi_araddr[9:2] == RIS_CONTROL_IDX) begin
        st_nxt.rdata = {24'h0, st_r.ctl};
      end else if (s_axi_araddr[9:2] == RIS_STATUS_ADDR[9:2]) begin
        st_nxt.rdata = {24'h0, primary_valid, secondary_valid,
          st_r.xtal_off, st_r.auto_seen, st_r.loop_sec, st_r.sec_en};
      end else begin
        st_nxt.rresp = RIS_RESP_SLVERR;
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // reference switch and crystal buffer
    st_nxt.loop_sec = {pick2.use_secondary, pick1.use_secondary};
    st_nxt.auto_seen = {pick2.auto_mode, pick1.auto_mode};
    sw = (st_nxt.loop_sec != st_r.loop_sec);
    if (sw && st_nxt.loop_sec == 2'b00 && !st_r.ctl[RIS_KEEP_BIT]) begin
      st_nxt.xtal_off = 1'b1;
    end else if (st_nxt.loop_sec != 2'b00 || st_r.ctl[RIS_KEEP_BIT]) begin
      st_nxt.xtal_off = 1'b0;
    end
    // outputs
    st_nxt.sec_mode = st_r.sel[RIS_SEC_MODE_LSB +: 2];
    st_nxt.pri_mode = st_r.sel[RIS_PRI_MODE_LSB +: 2];
    st_nxt.pri_en = !st_r.sel[RIS_PRI_MODE_LSB + 1];
    st_nxt.sec_en = (st_r.sel[RIS_SEC_MODE_LSB +: 2] != RIS_SEC_OFF) &&
      !(st_r.xtal_off &&
      st_r.sel[RIS_SEC_MODE_LSB +: 2] == RIS_SEC_CRYSTAL);
    st_nxt.sec_gain = st_r.ctl[RIS_SEC_GAIN_BIT];
    st_nxt.pri_gain = st_r.ctl[RIS_PRI_GAIN_BIT];
    st_nxt.skip = st_r.ctl[RIS_SKIP_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.sel <= RIS_SELECT_RST;
      st_r.ctl <= RIS_CONTROL_RST;
      st_r.sec_mode <= RIS_SELECT_RST[RIS_SEC_MODE_LSB +: 2];
      st_r.pri_mode <= RIS_SELECT_RST[RIS_PRI_MODE_LSB +: 2];
      st_r.pri_en <= 1'b1;
      st_r.sec_en <= 1'b1;
      st_r.sec_gain <= 1'b1;
      st_r.pri_gain <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = !st_r.aw_got;
  assign s_axi_wready = !st_r.w_got;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign secondary_buffer_mode = st_r.sec_mode;
  assign primary_buffer_mode = st_r.pri_mode;
  assign primary_enable = st_r.pri_en;
  assign secondary_enable = st_r.sec_en;
  assign secondary_buffer_gain = st_r.sec_gain;
  assign primary_buffer_gain = st_r.pri_gain;
  assign glitchfree_mux_skip = st_r.skip;
  assign first_loop_use_secondary = st_r.loop_sec[0];
  assign second_loop_use_secondary = st_r.loop_sec[1];

endmodule
`default_nettype wire

/* File: src/ris_pkg.sv */
// Contract
// - secondary buffer mode field, resets crystal
// - primary buffer mode, 2/3 disabled, resets differential
// - second loop reference choice field encoding
// - pin mode second loop: low/mid secondary, high auto
// - first loop reference choice, resets pin mode
// - pin mode first loop: low primary, else auto
// - glitchfree mux skip bit, reset zero
// - crystal buffer off after switch unless keep bit
// - secondary gain bit, resets maximum
// - primary gain bit, resets maximum
package ris_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  // printed offsets are not all multiples of four: indices, byte addr = 4*idx
  localparam logic [7:0] RIS_SELECT_IDX = 8'h32;
  localparam logic [7:0] RIS_CONTROL_IDX = 8'h33;
  localparam logic [9:0] RIS_SELECT_ADDR = {RIS_SELECT_IDX, 2'b00};
  localparam logic [9:0] RIS_CONTROL_ADDR = {RIS_CONTROL_IDX, 2'b00};
  localparam logic [9:0] RIS_STATUS_ADDR = 10'h0D0;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int RIS_SEC_MODE_LSB = 6;
  localparam int RIS_PRI_MODE_LSB = 4;
  localparam int RIS_LOOP2_LSB = 2;
  localparam int RIS_LOOP1_LSB = 0;
  localparam int RIS_SKIP_BIT = 7;
  localparam int RIS_KEEP_BIT = 2;
  localparam int RIS_SEC_GAIN_BIT = 1;
  localparam int RIS_PRI_GAIN_BIT = 0;
  localparam logic [7:0] RIS_SELECT_RST = 8'h95;
  localparam logic [7:0] RIS_CONTROL_RST = 8'h03;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] RIS_SEC_CRYSTAL = 2'h2;
  localparam logic [1:0] RIS_SEC_OFF = 2'h3;
  localparam logic [1:0] RIS_REF_AUTO = 2'h0;
  localparam logic [1:0] RIS_REF_PIN = 2'h1;
  localparam logic [1:0] RIS_REF_PRI = 2'h2;
  localparam logic [1:0] RIS_REF_SEC = 2'h3;
  localparam logic [1:0] RIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RIS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RIS_PIN_LOW,
    RIS_PIN_MID,
    RIS_PIN_HIGH
  } ris_pin_type;

  // per-loop status: use_secondary toward the analog side, auto_mode only to the status register
  typedef struct packed {
    logic use_secondary;
    logic auto_mode;
  } ris_loop_type;

endpackage

/* File: src/ris_ref_pick.sv */
`timescale 1ns/1ns
`default_nettype none
module ris_ref_pick
  import ris_pkg::*;
#(
  parameter bit PIN_LOW_SEC = 1'b0,
  parameter bit PIN_MID_SEC = 1'b0
) (
  // choice
  input wire logic [1:0] choice,
  input wire ris_pin_type pin,
  input wire logic primary_valid,
  // result
  output ris_loop_type pick
);

  logic auto_on;

  always_comb begin
    auto_on = 1'b0;
    pick.use_secondary = 1'b0;
    case (choice)
      RIS_REF_AUTO: auto_on = 1'b1;
      RIS_REF_PIN: begin
        if (pin == RIS_PIN_LOW) begin
          pick.use_secondary = PIN_LOW_SEC;
        end else if (pin == RIS_PIN_MID && PIN_MID_SEC) begin
          pick.use_secondary = 1'b1;
        end else begin
          auto_on = 1'b1;
        end
      end
      RIS_REF_PRI: pick.use_secondary = 1'b0;
      default: pick.use_secondary = 1'b1;
    endcase
    if (auto_on) begin
      pick.use_secondary = !primary_valid;
    end
    pick.auto_mode = auto_on;
  end

endmodule
`default_nettype wire

/* File: verif/ris_ref_source.sv */
`timescale 1ns/1ns
`default_nettype none
module ris_ref_source (
  // bench requests
  input wire logic aclk,
  input wire logic [1:0] pin_req,
  input wire logic pri_req,
  // levels at the block
  output logic [1:0] reference_choice_pin,
  output logic primary_valid,
  output logic secondary_valid
);
  // sources settle one cycle after a request
  always_ff @(posedge aclk) begin
    reference_choice_pin <= pin_req;
    primary_valid <= pri_req;
  end
  // crystal always oscillating
  assign secondary_valid = 1'b1;
endmodule
`default_nettype wire

/* File: verif/ris_top_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module ris_top_properties
  import ris_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // buffer controls
  input wire logic [1:0] secondary_buffer_mode,
  input wire logic [1:0] primary_buffer_mode,
  input wire logic primary_enable,
  input wire logic secondary_enable,
  input wire logic secondary_buffer_gain,
  input wire logic primary_buffer_gain,
  input wire logic glitchfree_mux_skip,
  input wire logic first_loop_use_secondary
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RESET_VALUES: assert property (disable iff (1'b0)
    !aresetn |=> secondary_buffer_mode == 2'h2 && primary_buffer_mode == 2'h1
    && secondary_buffer_gain && primary_buffer_gain && !glitchfree_mux_skip)
    else $error("reset values wrong");
  AST_PRI_ENABLE: assert property (
    primary_enable == !primary_buffer_mode[1]) else $error("primary enable");
  AST_SEC_OFF: assert property (
    secondary_buffer_mode == 2'h3 |-> !secondary_enable)
    else $error("secondary not off");
  AST_SEC_ON: assert property (
    !secondary_buffer_mode[1] |-> secondary_enable)
    else $error("secondary not on");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  AST_ARREADY_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready not a pulse");
  AST_WRITE_BLOCKED: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(first_loop_use_secondary));
endmodule
bind ris_top ris_top_properties ris_top_properties_inst (.*);
`default_nettype wire

/* File: verif/ris_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module ris_top_tb_top
  import ris_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, pri_req = 1'b1;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, e, g, seed = 32'h0FE0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, primary_valid, secondary_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_choice_pin, r;
  logic [1:0] pin_req = 2'h0, secondary_buffer_mode, primary_buffer_mode;
  logic primary_enable, secondary_enable, secondary_buffer_gain;
  logic primary_buffer_gain, glitchfree_mux_skip;
  logic first_loop_use_secondary, second_loop_use_secondary;
  logic [7:0] v;
  int errors = 0, samples_checked = 0, lag = 0;
  always #50 aclk = ~aclk;
  ris_top ris_top_inst (.*);
  ris_ref_source ris_ref_source_inst (.*);
  task automatic chk(input string n, input logic [31:0] x, y);
    samples_checked++;
    if (y !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask
  // lag: cycles before bready or rready is raised
  task automatic wr(input logic [9:0] a, input logic [31:0] w);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n >= lag) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n >= lag) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // loop source: 1 means secondary
  function automatic logic lp(input logic [1:0] c, p, input logic pv, two);
    case (c)
      2'h0: return !pv;
      2'h1: return (p == 2'h0 || (p == 2'h1 && two)) ? two : !pv;
      2'h2: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction
  task automatic rst_chk();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    g = 32'({secondary_buffer_mode, primary_buffer_mode,
      secondary_buffer_gain, primary_buffer_gain, glitchfree_mux_skip});
    chk("rst_out", 32'h4E, g);
    rd(RIS_SELECT_ADDR);
    chk("select", 32'h95, d);
    rd(RIS_CONTROL_ADDR);
    chk("control", 32'h03, d);
  endtask
  task automatic final_report();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    final_report();
  end
  initial begin
    rst_chk();
    wr(10'h100, 32'h0);
    chk("bad_wresp", 32'(RIS_RESP_SLVERR), 32'(r));
    rd(10'h100);
    chk("bad_read", 32'(RIS_RESP_SLVERR), {d[29:0], r});
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      v = seed[7:0];
      if (i < 4) v[3:0] = {2{i[1:0]}};
      pin_req <= seed[9:8];
      pri_req <= seed[10];
      wr(RIS_SELECT_ADDR, 32'(v));
      chk("wresp", 32'(RIS_RESP_OKAY), 32'(r));
      repeat (3) @(posedge aclk);
      e = 32'({v[7:4], !v[5], lp(v[1:0], seed[9:8], seed[10], 1'b0),
        lp(v[3:2], seed[9:8], seed[10], 1'b1)});
      g = 32'({secondary_buffer_mode, primary_buffer_mode, primary_enable,
        first_loop_use_secondary, second_loop_use_secondary});
      chk("route", e, g);
      if (v[7:6] != 2'h2) begin
        chk("sec_en", 32'(v[7:6] != 2'h3), 32'(secondary_enable));
      end
      rd(RIS_SELECT_ADDR);
      chk("select", 32'(v), d);
    end
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      lag = i % 4;
      wr(RIS_CONTROL_ADDR, seed);
      repeat (3) @(posedge aclk);
      g = 32'({glitchfree_mux_skip, secondary_buffer_gain,
        primary_buffer_gain});
      chk("ctl_out", 32'({seed[7], seed[1:0]}), g);
      rd(RIS_CONTROL_ADDR);
      chk("control", 32'(seed[7:0]), d);
    end
    for (int k = 0; k < 2; k++) begin
      wr(RIS_CONTROL_ADDR, k ? 32'h07 : 32'h03);
      wr(RIS_SELECT_ADDR, 32'h9F);
      wr(RIS_SELECT_ADDR, 32'h9A);
      repeat (3) @(posedge aclk);
      chk("crystal_on", 32'(k), 32'(secondary_enable));
      rd(RIS_STATUS_ADDR);
      e = {24'h0, pri_req, 1'b1, !k[0], 4'h0, k[0]};
      chk("status", e, d);
    end
    rst_chk();
    final_report();
  end
endmodule
`default_nettype wire
